// ---- cws_cfg.svh ----
`ifndef CWS_CFG_SVH
`define CWS_CFG_SVH
// Notes on behaviour
// - Key output high commands key-down; the keying switch closes while high.
// - Straight-key mode copies the synchronised key input to the key output.
// - Other modes drive the key output from the software key bit.
// - Carrier frequency is sixty times the selected sidetone frequency.
// - Sidetone alternates carrier duty between two values symmetric about half.
// - Duty alternation happens at the sidetone frequency.
// - Average duty of the modulated sidetone stays at exactly half.
// - Volume sets the size of the duty deviation from half.
// - Legacy mode gives a tone-rate square wave, duty 50% down below 1%.
// - Tone frequency and volume are software-held settings.
// - Sidetone sounds while the transmitter is keyed.
// - All timing derives from the system clock frequency constant.
// - Receive line stays in transmit state 10 ms after key-up.
// - Receive line high enables receive, low selects transmit.

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CWS_CLK_HZ 125000000
`define CWS_CARRIER_MULT 60
`define CWS_HALF_CARRIERS 5'h1D
`define CWS_HANG_MS 10
`define CWS_HANG_CYC (`CWS_CLK_HZ / 1000 * `CWS_HANG_MS)

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CWS_ADDR_CTRL 12'h000
`define CWS_ADDR_TONE 12'h004
`define CWS_ADDR_VOL 12'h008
`define CWS_ADDR_STAT 12'h00C

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CWS_CTRL_MODE 1:0
`define CWS_CTRL_LEGACY 2
`define CWS_CTRL_SWKEY 3
`define CWS_CTRL_RST 4'h0
`define CWS_TONE_RST 12'h2BC
`define CWS_TONE_MIN 12'h0C8
`define CWS_TONE_MAX 12'hFA0
`define CWS_VOL_RST 7'h08
`define CWS_PERIOD_RST 14'hBA0
`endif

// ---- cws_pkg.sv ----
package cws_pkg;
    // Keyer source selection
    typedef enum logic [1:0]
    {
        KEY_STRAIGHT = 2'h0,
        KEY_IAMBIC = 2'h1,
        KEY_BEACON = 2'h2
    } cws_keymode_type;

    // Transmit/receive sequencing states
    typedef enum logic [2:0]
    {
        ST_RX = 3'b001,
        ST_TX = 3'b010,
        ST_HANG = 3'b100
    } cws_txstate_type;

    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cws_apb_req_type;

    typedef struct packed
    {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cws_apb_rsp_type;
endpackage

// ---- cws_div.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Restoring divider: clock rate over carrier rate, one bit per cycle
// ----------------------------------------------------------------------
module cws_div
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic [26:0] dividend_i,
    input wire logic [17:0] divisor_i,
    output logic done_o,
    output logic [13:0] quot_o
);
    logic busy_r;
    logic [4:0] cnt_r;
    logic [17:0] rem_r;
    logic [26:0] q_r;
    logic done_r;
    wire [18:0] shifted = {rem_r, q_r[26]};
    wire ge = shifted >= {1'b0, divisor_i};
    wire [18:0] diff = shifted - {1'b0, divisor_i};

    // Divisor must stay still while busy; a new start restarts cleanly
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            busy_r <= 1'b0;
            cnt_r <= 5'h00;
            rem_r <= 18'h00000;
            q_r <= 27'h0000000;
            done_r <= 1'b0;
        end
        else if (start_i)
        begin
            busy_r <= 1'b1;
            cnt_r <= 5'h1B;
            rem_r <= 18'h00000;
            q_r <= dividend_i;
            done_r <= 1'b0;
        end
        else if (busy_r)
        begin
            rem_r <= ge ? diff[17:0] : shifted[17:0];
            q_r <= {q_r[25:0], ge};
            cnt_r <= cnt_r - 5'h01;
            busy_r <= (cnt_r != 5'h01);
            done_r <= (cnt_r == 5'h01);
        end
        else
        begin
            done_r <= 1'b0;
        end
    end

    // Quotient never exceeds 14 bits for the clamped tone range
    assign done_o = done_r;
    assign quot_o = q_r[13:0];
endmodule

// ---- cws_pwm.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Carrier counter with duty compare
// ----------------------------------------------------------------------
module cws_pwm
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [13:0] period_i,
    input wire logic [13:0] high_i,
    output logic pwm_o,
    output logic wrap_o
);
    logic [13:0] cnt_r;
    logic pwm_r;
    logic wrap_r;
    // Greater-or-equal so a shrinking period never strands the counter
    wire last = cnt_r >= (period_i - 14'h0001);

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            cnt_r <= 14'h0000;
            pwm_r <= 1'b0;
            wrap_r <= 1'b0;
        end
        else
        begin
            cnt_r <= last ? 14'h0000 : cnt_r + 14'h0001;
            pwm_r <= cnt_r < high_i;
            wrap_r <= last;
        end
    end

    assign pwm_o = pwm_r;
    assign wrap_o = wrap_r;
endmodule

// ---- cws_sidetone_key.sv ----
`timescale 1ns/1ps
`include "cws_cfg.svh"
// ----------------------------------------------------------------------
// CW key output, transmit/receive hang control and PWM sidetone
// ----------------------------------------------------------------------
module cws_sidetone_key
#(
    parameter int HANG_CYCLES = `CWS_HANG_CYC
)
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire cws_pkg::cws_apb_req_type apb_req_i,
    output cws_pkg::cws_apb_rsp_type apb_rsp_o,
    input wire logic key_in_i,
    output logic key_o,
    output logic rx_o,
    output logic tone_o
);
    import cws_pkg::*;

    // ------------------------------------------------------------------
    // Shared arithmetic
    // ------------------------------------------------------------------
    // Fraction vol/256 of x; vol up to 127 keeps the result below x/2
    function automatic logic [19:0] cws_scale
    (
        input logic [19:0] x,
        input logic [6:0] vol
    );
        logic [26:0] prod;
        prod = {7'h00, x} * {20'h00000, vol};
        return {1'b0, prod[26:8]};
    endfunction

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic [3:0] ctrl_r;
    logic [11:0] tone_r;
    logic [6:0] vol_r;
    logic [13:0] period_r;
    logic div_start_r;
    logic key_meta_r;
    logic key_sync_r;
    logic key_r;
    logic rx_r;
    cws_txstate_type st_r;
    cws_txstate_type st_nxt;
    logic [20:0] hang_r;
    logic [20:0] hang_nxt;
    logic [4:0] idx_r;
    logic phase_r;
    logic [19:0] lcnt_r;
    logic tone_r_out;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire sel_ctrl = apb_req_i.paddr == `CWS_ADDR_CTRL;
    wire sel_tone = apb_req_i.paddr == `CWS_ADDR_TONE;
    wire sel_vol = apb_req_i.paddr == `CWS_ADDR_VOL;
    wire sel_stat = apb_req_i.paddr == `CWS_ADDR_STAT;
    wire hit = sel_ctrl | sel_tone | sel_vol | sel_stat;
    // Access phase is two cycles: answer prepared, then completed
    wire access = apb_req_i.psel & apb_req_i.penable & !pready_r;
    wire commit = apb_req_i.psel & apb_req_i.penable & pready_r;
    wire wr_en = commit & apb_req_i.pwrite;
    wire wr_ctrl = wr_en & sel_ctrl;
    wire wr_tone = wr_en & sel_tone;
    wire wr_vol = wr_en & sel_vol;

    // Tone setting clamped so the carrier period fits its counter
    wire [11:0] wtone = apb_req_i.pwdata[11:0];
    wire [11:0] tone_clamp = (wtone < `CWS_TONE_MIN) ? `CWS_TONE_MIN :
        (wtone > `CWS_TONE_MAX) ? `CWS_TONE_MAX : wtone;

    wire [31:0] stat_word = {2'b00, period_r, 13'h0000,
        (st_r == ST_HANG), rx_r, key_r};
    wire [31:0] rd_mux =
        sel_ctrl ? {28'h0000000, ctrl_r} :
        sel_tone ? {20'h00000, tone_r} :
        sel_vol ? {25'h0000000, vol_r} :
        sel_stat ? stat_word : 32'h00000000;

    // Slave response flops
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            pready_r <= access;
            pslverr_r <= access & !hit;
            prdata_r <= access ? rd_mux : 32'h00000000;
        end
    end

    // Configuration registers, written at completion of the transfer
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            ctrl_r <= `CWS_CTRL_RST;
            tone_r <= `CWS_TONE_RST;
            vol_r <= `CWS_VOL_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= apb_req_i.pwdata[3:0];
            if (wr_tone)
                tone_r <= tone_clamp;
            if (wr_vol)
                vol_r <= apb_req_i.pwdata[6:0];
        end
    end

    // ------------------------------------------------------------------
    // Carrier period from tone setting
    // ------------------------------------------------------------------
    // Sixty carrier cycles per tone cycle, all from the clock rate
    wire [17:0] carrier_hz = 18'(tone_r * `CWS_CARRIER_MULT);
    wire [26:0] clk_hz = 27'(`CWS_CLK_HZ);
    wire div_done;
    wire [13:0] div_quot;

    cws_div u_div
    (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .start_i(div_start_r),
        .dividend_i(clk_hz),
        .divisor_i(carrier_hz),
        .done_o(div_done),
        .quot_o(div_quot)
    );

    // Start a division one cycle after a tone write, so the divisor
    // already holds the new setting
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            div_start_r <= 1'b0;
            period_r <= `CWS_PERIOD_RST;
        end
        else
        begin
            div_start_r <= wr_tone;
            if (div_done)
                period_r <= div_quot;
        end
    end

    // ------------------------------------------------------------------
    // Key input and key source
    // ------------------------------------------------------------------
    // Two-flop synchroniser for the key pin
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            key_meta_r <= 1'b0;
            key_sync_r <= 1'b0;
        end
        else
        begin
            key_meta_r <= key_in_i;
            key_sync_r <= key_meta_r;
        end
    end

    wire straight = ctrl_r[`CWS_CTRL_MODE] == KEY_STRAIGHT;
    wire key_src = straight ? key_sync_r
        : ctrl_r[`CWS_CTRL_SWKEY];

    // ------------------------------------------------------------------
    // Transmit/receive sequencing
    // ------------------------------------------------------------------
    // Hang delay lets the shaped envelope decay before receive returns
    always_comb
    begin
        st_nxt = st_r;
        hang_nxt = hang_r;
        case (st_r)
            ST_RX:
            begin
                if (key_src)
                    st_nxt = ST_TX;
            end
            ST_TX:
            begin
                if (!key_src)
                begin
                    st_nxt = ST_HANG;
                    hang_nxt = 21'(HANG_CYCLES - 1);
                end
            end
            ST_HANG:
            begin
                if (key_src)
                    st_nxt = ST_TX;
                else if (hang_r == 21'h000000)
                    st_nxt = ST_RX;
                else
                    hang_nxt = hang_r - 21'h000001;
            end
            default:
            begin
                st_nxt = ST_RX;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            st_r <= ST_RX;
            hang_r <= 21'h000000;
            key_r <= 1'b0;
            rx_r <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            hang_r <= hang_nxt;
            key_r <= key_src;
            rx_r <= (st_nxt == ST_RX);
        end
    end

    // ------------------------------------------------------------------
    // Sidetone duty selection
    // ------------------------------------------------------------------
    // Deviation is symmetric, so the two halves average to exactly half
    wire [13:0] half = {1'b0, period_r[13:1]};
    wire [19:0] dev_w = cws_scale({6'h00, period_r}, vol_r);
    wire [13:0] dev = dev_w[13:0];
    wire sounding = key_r;
    wire legacy = ctrl_r[`CWS_CTRL_LEGACY];
    wire mod_on = sounding & !legacy;
    wire [13:0] hi_cnt = !mod_on ? half
        : phase_r ? half + dev
        : half - dev;
    wire pwm_bit;
    wire pwm_wrap;

    cws_pwm u_pwm
    (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .period_i(period_r),
        .high_i(hi_cnt),
        .pwm_o(pwm_bit),
        .wrap_o(pwm_wrap)
    );

    // Phase flips every thirty carrier cycles: one tone period per sixty
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            idx_r <= 5'h00;
            phase_r <= 1'b0;
        end
        else if (pwm_wrap)
        begin
            if (idx_r == `CWS_HALF_CARRIERS)
            begin
                idx_r <= 5'h00;
                phase_r <= !phase_r;
            end
            else
            begin
                idx_r <= idx_r + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Legacy square-wave tone
    // ------------------------------------------------------------------
    // Trade-off: this mode shifts the average level with volume
    wire [19:0] lper = {period_r, 6'h00} - {4'h0, period_r, 2'b00};
    wire [19:0] lhigh = {1'b0, lper[19:1]} - cws_scale(lper, vol_r);
    wire lbit = lcnt_r < lhigh;

    // Held at zero while idle, so every legacy tone opens with a whole cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i || !(legacy & sounding))
            lcnt_r <= 20'h00000;
        else if (lcnt_r >= lper - 20'h00001)
            lcnt_r <= 20'h00000;
        else
            lcnt_r <= lcnt_r + 20'h00001;
    end

    // Output flop; silent legacy also falls back to the half-duty carrier
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            tone_r_out <= 1'b0;
        else if (legacy & sounding)
            tone_r_out <= lbit;
        else
            tone_r_out <= pwm_bit;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign key_o = key_r;
    assign rx_o = rx_r;
    assign tone_o = tone_r_out;
    assign apb_rsp_o = '{prdata: prdata_r, pready: pready_r,
        pslverr: pslverr_r};
endmodule

// ---- cws_sidetone_key_assertions.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker: key output, receive line and register bus
// ----------------------------------------------------------------------
module cws_sk_assertions
import cws_pkg::*;
#(
    parameter int HANG_CYCLES = 50
)
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire cws_pkg::cws_apb_req_type apb_req_i,
    input wire cws_pkg::cws_apb_rsp_type apb_rsp_o,
    input wire logic key_in_i,
    input wire logic key_o,
    input wire logic rx_o,
    input wire logic tone_o
);
    logic [3:0] ctrl_r;
    logic [2:0] since_r;
    logic seen_r;
    logic [31:0] hang_r;
    logic ctrl_wr;
    logic acc1;

    // Control write completes at the edge that sees pready
    assign ctrl_wr = apb_rsp_o.pready && apb_req_i.pwrite
        && apb_req_i.paddr == 12'h000;
    assign acc1 = apb_req_i.psel && apb_req_i.penable && !apb_rsp_o.pready;

    // Settle counter covers the key synchroniser after a mode change
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            ctrl_r <= 4'h0;
            since_r <= 3'h0;
            seen_r <= 1'b0;
            hang_r <= 32'h0;
        end
        else
        begin
            if (ctrl_wr)
                ctrl_r <= apb_req_i.pwdata[3:0];
            since_r <= ctrl_wr ? 3'h0 : since_r + {2'h0, since_r != 3'h7};
            seen_r <= seen_r | key_o;
            hang_r <= (key_o || rx_o) ? 32'h0 : hang_r + 32'h1;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    a_straight_copy: assert property (ctrl_r[1:0] == 2'h0
        && since_r == 3'h7 |-> key_o == $past(key_in_i, 3))
        else $error("key output does not follow key input");
    a_sw_key: assert property (ctrl_r[1:0] != 2'h0 && since_r == 3'h7
        |-> key_o == ctrl_r[3])
        else $error("key output does not follow software key");
    a_key_tx: assert property (key_o |-> !rx_o)
        else $error("receive line high while keyed");
    a_hang_hold: assert property ($fell(key_o) |-> !rx_o [*8])
        else $error("receive line returned too early");
    a_hang_bound: assert property (hang_r <= 32'(HANG_CYCLES + 2))
        else $error("receive line hang too long");
    a_rx_idle: assert property (!seen_r && !key_o |-> rx_o)
        else $error("receive line low before first key");
    a_ready_next: assert property (acc1 |=> apb_rsp_o.pready)
        else $error("pready late");
    a_ready_pulse: assert property (apb_rsp_o.pready
        |=> !apb_rsp_o.pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (acc1
        && apb_req_i.paddr > 12'h00C |=> apb_rsp_o.pslverr)
        else $error("no error on unmapped address");
endmodule

bind cws_sidetone_key cws_sk_assertions #(.HANG_CYCLES(HANG_CYCLES)) i_chk
(
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o),
    .key_in_i(key_in_i),
    .key_o(key_o),
    .rx_o(rx_o),
    .tone_o(tone_o)
);

// ---- cws_shaper_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Audio filter input: measures each period of tone_i, rise to rise
// ----------------------------------------------------------------------
module cws_shaper_model
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic tone_i,
    output logic [15:0] hi_len_o,
    output logic [15:0] per_len_o,
    output logic [15:0] n_per_o
);
    logic prev_r;
    logic [15:0] pcnt_r;
    logic [15:0] hcnt_r;
    logic rise;

    assign rise = tone_i && !prev_r;

    // High and total counts are latched at each rising edge of the tone
    always_ff @(posedge ref_clk_i)
    begin
        prev_r <= resetn_i && tone_i;
        if (!resetn_i || rise)
        begin
            pcnt_r <= 16'h1;
            hcnt_r <= 16'h1;
        end
        else
        begin
            pcnt_r <= pcnt_r + 16'h1;
            hcnt_r <= hcnt_r + {15'h0, tone_i};
        end
        if (!resetn_i)
            n_per_o <= 16'h0;
        else if (rise)
            n_per_o <= n_per_o + 16'h1;
        if (resetn_i && rise)
            per_len_o <= pcnt_r;
        if (resetn_i && rise)
            hi_len_o <= hcnt_r;
    end
endmodule

// ---- tb_cws_sidetone_key.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
        end \
    end
module tb_cws_sidetone_key;
import cws_pkg::*;
    localparam int HANG = 50;
    logic clk = 1'b0;
    logic resetn;
    cws_apb_req_type req;
    cws_apb_rsp_type rsp;
    logic key_in;
    logic key;
    logic rx;
    logic tone;
    logic [15:0] hi_len;
    logic [15:0] per_len;
    logic [15:0] n_per;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] q;
    logic err;

    always #4 clk = ~clk;

    cws_sidetone_key #(.HANG_CYCLES(HANG)) i_dut (.ref_clk_i(clk),
        .resetn_i(resetn), .apb_req_i(req), .apb_rsp_o(rsp),
        .key_in_i(key_in), .key_o(key), .rx_o(rx), .tone_o(tone));
    cws_shaper_model i_filt (.ref_clk_i(clk), .resetn_i(resetn),
        .tone_i(tone), .hi_len_o(hi_len), .per_len_o(per_len),
        .n_per_o(n_per));

    // Watchdog against a hung wait
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 110000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer; holds the request until pready is sampled
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
            @(posedge clk);
        while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task chk_rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", e, q);
        `CHK("pslverr", ee, err);
    endtask

    task wait_per(input int n);
        logic [15:0] s;
        repeat (n)
        begin
            s = n_per;
            while (n_per === s)
                @(posedge clk);
        end
    endtask

    task t_regs;
        chk_rd(12'h000, 32'h0, 1'b0);
        chk_rd(12'h004, 32'h2BC, 1'b0);
        chk_rd(12'h008, 32'h8, 1'b0);
        chk_rd(12'h00C, 32'h0BA00002, 1'b0);
        chk_rd(12'h010, 32'h0, 1'b1);
        apb(1'b1, 12'h004, 32'h64);
        chk_rd(12'h004, 32'hC8, 1'b0);
        $display("test regs done");
    endtask

    task t_silent;
        apb(1'b1, 12'h004, 32'hFA0);
        wait_per(3);
        `CHK("period", 16'd520, per_len);
        `CHK("high", 16'd260, hi_len);
        chk_rd(12'h00C, 32'h02080002, 1'b0);
        $display("test silent done");
    endtask

    task t_keys;
        key_in <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("key", 1'b1, key);
        `CHK("rx", 1'b0, rx);
        key_in <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK("key", 1'b0, key);
        repeat (HANG - 10) @(posedge clk);
        `CHK("rx", 1'b0, rx);
        chk_rd(12'h00C, 32'h02080004, 1'b0);
        repeat (20) @(posedge clk);
        `CHK("rx", 1'b1, rx);
        key_in <= 1'b1;
        for (int m = 1; m < 3; m++)
        begin
            apb(1'b1, 12'h000, 32'(8 + m));
            repeat (5) @(posedge clk);
            `CHK("key", 1'b1, key);
            apb(1'b1, 12'h000, 32'(m));
            repeat (5) @(posedge clk);
            `CHK("key", 1'b0, key);
        end
        key_in <= 1'b0;
        apb(1'b1, 12'h000, 32'h0);
        repeat (HANG + 20) @(posedge clk);
        $display("test keys done");
    endtask

    task t_tone;
        int sum;
        int up;
        sum = 0;
        up = 0;
        key_in <= 1'b1;
        wait_per(2);
        for (int i = 0; i < 60; i++)
        begin
            wait_per(1);
            sum += hi_len;
            if (hi_len === 16'd276)
                up++;
            else
                `CHK("high", 16'd244, hi_len);
        end
        `CHK("sum", 15600, sum);
        `CHK("up", 30, up);
        // Larger deviation: 64/256 of a 520-clock carrier swings by 130
        apb(1'b1, 12'h008, 32'h40);
        chk_rd(12'h008, 32'h40, 1'b0);
        wait_per(3);
        if (hi_len !== 16'd390)
            `CHK("loud", 16'd130, hi_len);
        key_in <= 1'b0;
        repeat (HANG + 20) @(posedge clk);
        $display("test tone done");
    endtask

    task t_legacy;
        apb(1'b1, 12'h000, 32'h4);
        key_in <= 1'b1;
        // Skip the carrier rise that may land as the square wave takes over
        while (key !== 1'b1)
            @(posedge clk);
        @(posedge clk);
        wait_per(2);
        `CHK("period", 16'd31200, per_len);
        `CHK("high", 16'd7800, hi_len);
        $display("test legacy done");
    endtask

    // Reset for 20 cycles, then the scenarios in order
    initial
    begin
        resetn = 1'b0;
        req = '0;
        key_in = 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_silent();
        t_keys();
        t_tone();
        t_legacy();
        end_of_test();
    end
endmodule
